// File: verilog/piru_regs.svh
// Purpose: register map and field constants of the regulator unit
// Assumes: APB, 32-bit data, one register per aligned word at four times its index
// Notes: printed offsets are byte-granular, so each one is kept as an index
`ifndef PIRU_REGS_SVH
`define PIRU_REGS_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define PIRU_IDX_CTRL0 16'h40E0
`define PIRU_IDX_START 16'h409E
`define PIRU_IDX_UEK 16'h40E8
`define PIRU_IDX_UUK 16'h40EA
`define PIRU_IDX_UKP 16'h40EC
`define PIRU_IDX_UKI 16'h40EE
`define PIRU_IDX_UMAX 16'h40F0
`define PIRU_IDX_UMIN 16'h40F2
`define PIRU_IDX_KM 16'h40F3
`define PIRU_IDX_IEK 16'h40F4
`define PIRU_IDX_IUK 16'h40F6
`define PIRU_IDX_IKP 16'h40F8
`define PIRU_IDX_IKI 16'h40FA
`define PIRU_IDX_IMAX 16'h40FC
`define PIRU_IDX_IMIN 16'h40FE
`define PIRU_IDX_GCR 16'h00F9
`define PIRU_IDX_GEK 16'h00EA
`define PIRU_IDX_GEK1 16'h00E2
`define PIRU_IDX_GUK 16'h00EC
`define PIRU_IDX_GUKS 16'h00E4
`define PIRU_IDX_GKP 16'h00EE
`define PIRU_IDX_GKI 16'h00F2
`define PIRU_IDX_GMAX 16'h00F4
`define PIRU_IDX_GMIN 16'h00F6

// ----------------------------------------
// Fields and timing
// ----------------------------------------
`define PIRU_BIT_ENABLE 0
`define PIRU_BIT_VGO 7
`define PIRU_BIT_IGO 6
`define PIRU_BIT_GGO 1
`define PIRU_DLY_HI 15
`define PIRU_DLY_LO 12
`define PIRU_PER_HI 11
`define PIRU_PER_LO 0
`define PIRU_DLY_CLKS 2
`define PIRU_KP_FRAC 10
`define PIRU_KI_FRAC 15
`define PIRU_CALC_CYC 3'h3

`endif

// File: verilog/piru_pkg.sv
// Purpose: shared types of the regulator unit
// Assumes: constants live in piru_regs.svh
// Notes: none
package piru_pkg;
  typedef enum logic [1:0] {
    PIRU_IDLE = 2'b00,
    PIRU_CALC = 2'b01,
    PIRU_DONE = 2'b10
  } piru_state_t;
endpackage

// File: verilog/piru_core.sv
// Purpose: one incremental PI step with clamping
// Assumes: go is a one-cycle pulse; operands sampled with it, limits stable until done
// Notes: fixed latency; result valid on the cycle done pulses
`timescale 1ns/1ps
`include "piru_regs.svh"
module piru_core #(
  parameter int KP_FRAC = `PIRU_KP_FRAC,
  parameter int KI_FRAC = `PIRU_KI_FRAC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Request
  input wire logic go,
  input wire logic signed [15:0] ek,
  input wire logic signed [15:0] ek1,
  input wire logic signed [31:0] uk1,
  input wire logic signed [15:0] kp,
  input wire logic signed [15:0] ki,
  input wire logic signed [15:0] ukmax,
  input wire logic signed [15:0] ukmin,
  // Answer
  output logic done,
  output logic signed [31:0] uk
);
  typedef struct packed {
    piru_pkg::piru_state_t st;
    logic [2:0] cnt;
    logic signed [47:0] acc;
    logic signed [31:0] res;
    logic dn;
  } piru_core_st_t;
  piru_core_st_t s_reg, s_next;
  logic signed [47:0] p_term, i_term, sum, maxw, minw;
  always_comb begin
    // Result kept with 16 fraction bits below the output word
    p_term = ($signed({{31{1'b0}}, 1'b0} + 48'(kp)) * 48'(ek - ek1)) <<< (16 - KP_FRAC);
    i_term = (48'(ki) * 48'(ek)) <<< (16 - KI_FRAC);
    sum = 48'(uk1) + p_term + i_term;
    maxw = 48'(ukmax) <<< 16;
    minw = 48'(ukmin) <<< 16;
    s_next = s_reg;
    s_next.dn = 1'b0;
    unique case (s_reg.st)
      piru_pkg::PIRU_IDLE: begin
        if (go) begin
          s_next.st = piru_pkg::PIRU_CALC;
          s_next.cnt = 3'h1;
          s_next.acc = sum;
        end
      end
      piru_pkg::PIRU_CALC: begin
        s_next.cnt = s_reg.cnt + 3'h1;
        if (s_reg.acc > maxw) begin
          s_next.acc = maxw;
        end else if (s_reg.acc < minw) begin
          s_next.acc = minw;
        end
        if (s_reg.cnt == `PIRU_CALC_CYC) begin
          s_next.st = piru_pkg::PIRU_DONE;
          s_next.res = s_reg.acc[31:0];
          s_next.dn = 1'b1;
        end
      end
      piru_pkg::PIRU_DONE: begin
        s_next.st = piru_pkg::PIRU_IDLE;
      end
      default: begin
        s_next.st = piru_pkg::PIRU_IDLE;
      end
    endcase
  end
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign done = s_reg.dn;
  assign uk = s_reg.res;
endmodule

// File: verilog/piru_top.sv
// Purpose: general and two special PI regulators behind an APB slave
// Assumes: single 50 MHz clock, synchronous active-low reset
// Notes: carrier period strobe comes from the correction timer outside
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "piru_regs.svh"
module piru_top #(
  parameter int KP_FRAC = `PIRU_KP_FRAC,
  parameter int KI_FRAC = `PIRU_KI_FRAC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [17:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Correction timer side
  input wire logic CARRIER_TICK,
  input wire logic SAMPLE_REQ,
  output logic SAMPLE_TRIG,
  output logic OUTER_TICK,
  output logic CORRECTION_ENABLE,
  output logic [7:0] CORRECTION_GAIN
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic en;
    logic [15:0] uek, uuk, ukp, uki, umax, umin;
    logic [15:0] iek, iuk, ikp, iki, imax, imin;
    logic [15:0] uek1, iek1;
    logic [15:0] gek, gek1, guk, guks, gkp, gki, gmax, gmin;
    logic gbusy;
    logic vgo, igo, ggo;
    logic [5:0] dly;
    logic dly_run;
    logic trig;
    logic [11:0] outer_cnt;
    logic outer;
    logic [31:0] rdata;
  } piru_st_t;
  piru_st_t s_reg, s_next;

  logic wr, rd;
  logic [15:0] idx, wd;
  logic [11:0] period;
  logic vdone, idone, gdone;
  logic [31:0] vuk, iuk_w, guk_w;
  logic signed [15:0] umin_eff, imin_eff;

  assign idx = PADDR[17:2];
  assign wd = PWDATA[15:0];
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign period = s_reg.imin[`PIRU_PER_HI:`PIRU_PER_LO];
  // Shared registers act as limits only with correction off
  assign umin_eff = s_reg.en ? 16'sh0000 : s_reg.umin;
  assign imin_eff = s_reg.en ? 16'sh0000 : s_reg.imin;

  // ----------------------------------------
  // Regulators
  // ----------------------------------------
  // Special loops use their own sets and outputs, apart from the general one
  piru_core #(.KP_FRAC(KP_FRAC), .KI_FRAC(KI_FRAC)) u_volt (
    .CLK(CLK), .NRST(NRST), .go(s_reg.vgo),
    .ek(s_reg.uek), .ek1(s_reg.uek1), .uk1({s_reg.uuk, 16'h0000}),
    .kp(s_reg.ukp), .ki(s_reg.uki), .ukmax(s_reg.umax), .ukmin(umin_eff),
    .done(vdone), .uk(vuk));
  piru_core #(.KP_FRAC(KP_FRAC), .KI_FRAC(KI_FRAC)) u_curr (
    .CLK(CLK), .NRST(NRST), .go(s_reg.igo),
    .ek(s_reg.iek), .ek1(s_reg.iek1), .uk1({s_reg.iuk, 16'h0000}),
    .kp(s_reg.ikp), .ki(s_reg.iki), .ukmax(s_reg.imax), .ukmin(imin_eff),
    .done(idone), .uk(iuk_w));
  piru_core #(.KP_FRAC(KP_FRAC), .KI_FRAC(KI_FRAC)) u_gen (
    .CLK(CLK), .NRST(NRST), .go(s_reg.ggo),
    .ek(s_reg.gek), .ek1(s_reg.gek1), .uk1({s_reg.guk, s_reg.guks}),
    .kp(s_reg.gkp), .ki(s_reg.gki), .ukmax(s_reg.gmax), .ukmin(s_reg.gmin),
    .done(gdone), .uk(guk_w));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.vgo = 1'b0;
    s_next.igo = 1'b0;
    s_next.ggo = 1'b0;
    s_next.trig = 1'b0;
    s_next.outer = 1'b0;
    // Register writes
    if (wr) begin
      unique case (idx)
        `PIRU_IDX_CTRL0: s_next.en = PWDATA[`PIRU_BIT_ENABLE];
        `PIRU_IDX_START: begin
          if (PWDATA[`PIRU_BIT_VGO]) begin
            s_next.vgo = 1'b1;
          end
          if (PWDATA[`PIRU_BIT_IGO]) begin
            s_next.igo = 1'b1;
          end
        end
        `PIRU_IDX_UEK: s_next.uek = wd;
        `PIRU_IDX_UUK: s_next.uuk = wd;
        `PIRU_IDX_UKP: s_next.ukp = {1'b0, wd[14:0]};
        `PIRU_IDX_UKI: s_next.uki = {1'b0, wd[14:0]};
        `PIRU_IDX_UMAX: s_next.umax = wd;
        `PIRU_IDX_UMIN: s_next.umin = wd;
        `PIRU_IDX_KM: s_next.umin[7:0] = PWDATA[7:0];
        `PIRU_IDX_IEK: s_next.iek = wd;
        `PIRU_IDX_IUK: s_next.iuk = wd;
        `PIRU_IDX_IKP: s_next.ikp = {1'b0, wd[14:0]};
        `PIRU_IDX_IKI: s_next.iki = {1'b0, wd[14:0]};
        `PIRU_IDX_IMAX: s_next.imax = wd;
        `PIRU_IDX_IMIN: s_next.imin = wd;
        `PIRU_IDX_GCR: begin
          if (PWDATA[`PIRU_BIT_GGO] && !s_reg.gbusy) begin
            s_next.ggo = 1'b1;
            s_next.gbusy = 1'b1;
          end
        end
        `PIRU_IDX_GEK: s_next.gek = wd;
        `PIRU_IDX_GEK1: s_next.gek1 = wd;
        `PIRU_IDX_GUK: s_next.guk = wd;
        `PIRU_IDX_GUKS: s_next.guks = wd;
        `PIRU_IDX_GKP: s_next.gkp = wd;
        `PIRU_IDX_GKI: s_next.gki = wd;
        `PIRU_IDX_GMAX: s_next.gmax = wd;
        `PIRU_IDX_GMIN: s_next.gmin = wd;
        default: begin
        end
      endcase
    end
    // Calculation results and carried-over error
    if (vdone) begin
      s_next.uuk = vuk[31:16];
      s_next.uek1 = s_reg.uek;
    end
    if (idone) begin
      s_next.iuk = iuk_w[31:16];
      s_next.iek1 = s_reg.iek;
    end
    if (gdone) begin
      s_next.guk = guk_w[31:16];
      s_next.guks = guk_w[15:0];
      s_next.gek1 = s_reg.gek;
      s_next.gbusy = 1'b0;
    end
    // Sampling delay: field value times two clocks
    if (s_reg.en && SAMPLE_REQ) begin
      s_next.dly = 6'(32'(s_reg.imin[`PIRU_DLY_HI:`PIRU_DLY_LO]) * `PIRU_DLY_CLKS);
      s_next.dly_run = 1'b1;
    end else if (s_reg.dly_run) begin
      if (s_reg.dly == 6'h00) begin
        s_next.dly_run = 1'b0;
        s_next.trig = 1'b1;
      end else begin
        s_next.dly = s_reg.dly - 6'h01;
      end
    end
    // Outer loop runs once per period carrier ticks
    if (!s_reg.en) begin
      s_next.outer_cnt = 12'h000;
    end else if (CARRIER_TICK) begin
      if (s_reg.outer_cnt + 12'h001 >= period) begin
        s_next.outer_cnt = 12'h000;
        s_next.outer = 1'b1;
      end else begin
        s_next.outer_cnt = s_reg.outer_cnt + 12'h001;
      end
    end
    // Read data captured in the setup phase
    if (rd) begin
      unique case (idx)
        `PIRU_IDX_CTRL0: s_next.rdata = {31'h0, s_reg.en};
        `PIRU_IDX_UEK: s_next.rdata = {16'h0, s_reg.uek};
        `PIRU_IDX_UUK: s_next.rdata = {16'h0, s_reg.uuk};
        `PIRU_IDX_UKP: s_next.rdata = {16'h0, s_reg.ukp};
        `PIRU_IDX_UKI: s_next.rdata = {16'h0, s_reg.uki};
        `PIRU_IDX_UMAX: s_next.rdata = {16'h0, s_reg.umax};
        `PIRU_IDX_UMIN: s_next.rdata = {16'h0, s_reg.umin};
        `PIRU_IDX_KM: s_next.rdata = {24'h0, s_reg.umin[7:0]};
        `PIRU_IDX_IEK: s_next.rdata = {16'h0, s_reg.iek};
        `PIRU_IDX_IUK: s_next.rdata = {16'h0, s_reg.iuk};
        `PIRU_IDX_IKP: s_next.rdata = {16'h0, s_reg.ikp};
        `PIRU_IDX_IKI: s_next.rdata = {16'h0, s_reg.iki};
        `PIRU_IDX_IMAX: s_next.rdata = {16'h0, s_reg.imax};
        `PIRU_IDX_IMIN: s_next.rdata = {16'h0, s_reg.imin};
        `PIRU_IDX_GCR: s_next.rdata = {30'h0, s_reg.gbusy, 1'b0};
        `PIRU_IDX_GEK: s_next.rdata = {16'h0, s_reg.gek};
        `PIRU_IDX_GEK1: s_next.rdata = {16'h0, s_reg.gek1};
        `PIRU_IDX_GUK: s_next.rdata = {16'h0, s_reg.guk};
        `PIRU_IDX_GUKS: s_next.rdata = {16'h0, s_reg.guks};
        `PIRU_IDX_GKP: s_next.rdata = {16'h0, s_reg.gkp};
        `PIRU_IDX_GKI: s_next.rdata = {16'h0, s_reg.gki};
        `PIRU_IDX_GMAX: s_next.rdata = {16'h0, s_reg.gmax};
        `PIRU_IDX_GMIN: s_next.rdata = {16'h0, s_reg.gmin};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Zero-wait slave; unmapped writes are simply dropped
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign PRDATA = s_reg.rdata;
  assign SAMPLE_TRIG = s_reg.trig;
  assign OUTER_TICK = s_reg.outer;
  assign CORRECTION_ENABLE = s_reg.en;
  // Gain only reaches the correction path while it is enabled
  assign CORRECTION_GAIN = s_reg.en ? s_reg.umin[7:0] : 8'h00;
endmodule

// File: verif/piru_top_properties.sv
// Purpose: port-level properties of the regulator unit
// Assumes: one clock, synchronous active-low reset
// Notes: delay check expects sample requests spaced apart
`timescale 1ns/1ps
`include "piru_regs.svh"
module piru_props (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [17:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Correction timer side
  input wire logic CARRIER_TICK,
  input wire logic SAMPLE_REQ,
  input wire logic SAMPLE_TRIG,
  input wire logic OUTER_TICK,
  input wire logic CORRECTION_ENABLE,
  input wire logic [7:0] CORRECTION_GAIN
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic wr_acc;
  logic ctl_wr;
  logic km_wr;
  logic go_wr;
  logic rd_gcr;
  logic [3:0] dly_reg;
  logic [5:0] trig_reg;
  logic [5:0] quiet_reg;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign ctl_wr = wr_acc && PADDR[17:2] == `PIRU_IDX_CTRL0;
  assign km_wr = wr_acc && PADDR[17:2] == `PIRU_IDX_KM;
  assign go_wr = wr_acc && PADDR[17:2] == `PIRU_IDX_GCR && PWDATA[1];
  assign rd_gcr = PSEL && PENABLE && !PWRITE && PADDR[17:2] == `PIRU_IDX_GCR;
  // Counters saturate so a stale request never wraps into a false match
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      dly_reg <= 4'h0;
      trig_reg <= 6'h3F;
      quiet_reg <= 6'h3F;
    end else begin
      if (wr_acc && PADDR[17:2] == `PIRU_IDX_IMIN) begin
        dly_reg <= PWDATA[15:12];
      end
      if (SAMPLE_REQ && CORRECTION_ENABLE) begin
        trig_reg <= 6'h01;
      end else if (trig_reg != 6'h3F) begin
        trig_reg <= trig_reg + 6'h01;
      end
      if (CORRECTION_ENABLE) begin
        quiet_reg <= 6'h00;
      end else if (quiet_reg != 6'h3F) begin
        quiet_reg <= quiet_reg + 6'h01;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_gain_gated: assert property (!CORRECTION_ENABLE |-> CORRECTION_GAIN == 8'h00)
    else $error("gain visible while correction off");
  chk_gain_write: assert property (km_wr && CORRECTION_ENABLE |=> CORRECTION_GAIN == $past(PWDATA[7:0]))
    else $error("gain does not follow its write");
  chk_enable_write: assert property (ctl_wr |=> CORRECTION_ENABLE == $past(PWDATA[0]))
    else $error("enable does not follow its write");
  chk_enable_cause: assert property ($changed(CORRECTION_ENABLE) |-> $past(ctl_wr))
    else $error("enable changed without a write");
  chk_trig_delay: assert property (SAMPLE_TRIG |-> trig_reg == {1'b0, dly_reg, 1'b0} + 6'h02)
    else $error("sample trigger at wrong delay");
  chk_quiet_off: assert property (quiet_reg > 6'h22 |-> !SAMPLE_TRIG && !OUTER_TICK)
    else $error("timer strobe while correction off");
  chk_outer_carrier: assert property (OUTER_TICK |-> $past(CARRIER_TICK))
    else $error("outer strobe without carrier tick");
  chk_busy_read: assert property (go_wr |-> ##3 (!rd_gcr || PRDATA[1]))
    else $error("busy not shown after start");
  cover property (SAMPLE_TRIG);
  cover property (OUTER_TICK);
  cover property (rd_gcr && PRDATA[1]);
endmodule

bind piru_top piru_props u_props (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .CARRIER_TICK(CARRIER_TICK), .SAMPLE_REQ(SAMPLE_REQ),
  .SAMPLE_TRIG(SAMPLE_TRIG), .OUTER_TICK(OUTER_TICK), .CORRECTION_ENABLE(CORRECTION_ENABLE),
  .CORRECTION_GAIN(CORRECTION_GAIN));

// File: verif/pi_regulator_unit_test.sv
// Purpose: self-checking bench of the regulator unit
// Assumes: zero-wait APB slave, one idle cycle between transfers
// Notes: reads are queued with their expectation and judged by the monitor
`timescale 1ns/1ps
`include "piru_regs.svh"
module pi_regulator_unit_test;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [17:0] PADDR = 18'h00000;
  logic [31:0] PWDATA = 32'h00000000;
  logic CARRIER_TICK = 1'b0;
  logic SAMPLE_REQ = 1'b0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, SAMPLE_TRIG, OUTER_TICK, CORRECTION_ENABLE;
  logic [7:0] CORRECTION_GAIN;
  int err_total = 0;
  int check_count = 0;
  int outer_n = 0;
  int n;
  logic [15:0] seed = 16'hA5A5;
  logic [15:0] v;
  logic [31:0] rdat;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  string nm_q[$];
  logic [15:0] ridx[8] = '{`PIRU_IDX_UMIN, `PIRU_IDX_KM, `PIRU_IDX_IEK, `PIRU_IDX_IUK,
    `PIRU_IDX_IKP, `PIRU_IDX_IKI, `PIRU_IDX_IMAX, `PIRU_IDX_IMIN};
  logic [15:0] gidx[8] = '{`PIRU_IDX_GEK1, `PIRU_IDX_GUK, `PIRU_IDX_GUKS, `PIRU_IDX_GEK,
    `PIRU_IDX_GKP, `PIRU_IDX_GKI, `PIRU_IDX_GMAX, `PIRU_IDX_GMIN};
  logic [15:0] gval[8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0100, 16'h0401, 16'h0000,
    16'h7FFF, 16'h8000};
  int dl[3] = '{0, 5, 15};

  always #10 CLK = ~CLK;

  piru_top u_dut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CARRIER_TICK(CARRIER_TICK), .SAMPLE_REQ(SAMPLE_REQ), .SAMPLE_TRIG(SAMPLE_TRIG),
    .OUTER_TICK(OUTER_TICK), .CORRECTION_ENABLE(CORRECTION_ENABLE),
    .CORRECTION_GAIN(CORRECTION_GAIN));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until PREADY is seen high at a rising edge
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rdat = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    apb(1'b1, idx, {16'h0000, d});
  endtask

  // A zero mask marks a poll whose value is not judged
  task automatic rd(input string nm, input logic [15:0] idx, input logic [31:0] e,
    input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    nm_q.push_back(nm);
    apb(1'b0, idx, 32'h00000000);
  endtask

  task automatic pi_run(input logic cur, input logic [15:0] ek, kp, ki, mx, mn, e);
    wr(cur ? `PIRU_IDX_IEK : `PIRU_IDX_UEK, ek);
    wr(cur ? `PIRU_IDX_IKP : `PIRU_IDX_UKP, kp);
    wr(cur ? `PIRU_IDX_IKI : `PIRU_IDX_UKI, ki);
    wr(cur ? `PIRU_IDX_IMAX : `PIRU_IDX_UMAX, mx);
    wr(cur ? `PIRU_IDX_IMIN : `PIRU_IDX_UMIN, mn);
    wr(`PIRU_IDX_START, cur ? 16'h0040 : 16'h0080);
    repeat (5) @(posedge CLK);
    rd("pi_out", cur ? `PIRU_IDX_IUK : `PIRU_IDX_UUK, {16'h0000, e}, 32'h0000FFFF);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Monitor and watchdog
  // ----------------------------------------
  always @(posedge CLK) begin
    if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1 && exp_q.size() > 0) begin
      if (msk_q[0] != 32'h00000000) begin
        chk(nm_q[0], exp_q[0], PRDATA & msk_q[0]);
      end
      exp_q.delete(0);
      msk_q.delete(0);
      nm_q.delete(0);
    end
    // Slave never flags an error, unmapped accesses included
    if (PSEL && PENABLE && PREADY === 1'b1) begin
      chk("slverr", 32'h00000000, {31'h00000000, PSLVERR});
    end
    if (OUTER_TICK === 1'b1) begin
      outer_n++;
    end
  end

  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    foreach (ridx[i]) rd("reset", ridx[i], 32'h00000000, 32'h0000FFFF);
    for (int i = 2; i < 8; i++) begin
      v = xs();
      wr(ridx[i], v);
      rd("rw", ridx[i], {16'h0000, (i == 4 || i == 5) ? v & 16'h7FFF : v}, 32'hFFFF);
    end
    wr(16'h0010, 16'hFFFF);
    rd("unmapped", 16'h0010, 32'h00000000, 32'hFFFFFFFF);
    wr(`PIRU_IDX_IUK, 16'h0000);
    pi_run(1'b1, 16'h0100, 16'h0400, 16'h0000, 16'h7FFF, 16'h8000, 16'h0100);
    pi_run(1'b1, 16'h0100, 16'h0400, 16'h4000, 16'h7FFF, 16'h8000, 16'h0180);
    pi_run(1'b1, 16'h1000, 16'h0400, 16'h7FFF, 16'h1234, 16'h8000, 16'h1234);
    pi_run(1'b1, 16'hF000, 16'h0400, 16'h7FFF, 16'h7FFF, 16'hF000, 16'hF000);
    pi_run(1'b0, 16'h0200, 16'h0400, 16'h0000, 16'h7FFF, 16'h8000, 16'h0200);
    wr(`PIRU_IDX_IEK, 16'h7000);
    wr(`PIRU_IDX_START, 16'h0000);
    repeat (5) @(posedge CLK);
    rd("cur_keep", `PIRU_IDX_IUK, 32'h0000F000, 32'h0000FFFF);
    foreach (gidx[i]) wr(gidx[i], gval[i]);
    wr(`PIRU_IDX_GCR, 16'h0002);
    rd("busy", `PIRU_IDX_GCR, 32'h00000002, 32'h00000002);
    n = 0;
    do begin
      rd("poll", `PIRU_IDX_GCR, 32'h00000000, 32'h00000000);
      n++;
    end while (rdat[1] !== 1'b0 && n < 20);
    chk("busy_clear", 32'h00000000, {31'h00000000, rdat[1]});
    rd("gen_hi", `PIRU_IDX_GUK, 32'h00000100, 32'h0000FFFF);
    rd("gen_lo", `PIRU_IDX_GUKS, 32'h00004000, 32'h0000FFFF);
    rd("gen_ek1", `PIRU_IDX_GEK1, 32'h00000100, 32'h0000FFFF);
    wr(`PIRU_IDX_KM, 16'h005A);
    chk("gain_off", 32'h00000000, {24'h000000, CORRECTION_GAIN});
    wr(`PIRU_IDX_CTRL0, 16'h0001);
    chk("enable", 32'h00000001, {31'h00000000, CORRECTION_ENABLE});
    chk("gain_on", 32'h0000005A, {24'h000000, CORRECTION_GAIN});
    v = xs();
    wr(`PIRU_IDX_KM, v);
    chk("gain_new", {24'h000000, v[7:0]}, {24'h000000, CORRECTION_GAIN});
    foreach (dl[i]) begin
      wr(`PIRU_IDX_IMIN, {dl[i][3:0], 12'h003});
      SAMPLE_REQ <= 1'b1;
      @(posedge CLK);
      SAMPLE_REQ <= 1'b0;
      n = 0;
      do begin
        @(posedge CLK);
        n++;
      end while (SAMPLE_TRIG !== 1'b1 && n < 40);
      chk("trig_delay", 32'(2 * dl[i] + 2), 32'(n));
    end
    outer_n = 0;
    repeat (12) begin
      CARRIER_TICK <= 1'b1;
      @(posedge CLK);
      CARRIER_TICK <= 1'b0;
      repeat (3) @(posedge CLK);
    end
    repeat (2) @(posedge CLK);
    chk("outer_ticks", 32'h00000004, 32'(outer_n));
    wr(`PIRU_IDX_CTRL0, 16'h0000);
    chk("gain_gone", 32'h00000000, {24'h000000, CORRECTION_GAIN});
    end_of_test();
  end
endmodule
